/* include/ddc_ctrl_pkg.sv */
// Shared constants for the down-converter overrange and oscillator preset control
package ddc_ctrl_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] IDX_THR_I = 12'h206;
  localparam logic [11:0] IDX_THR_Q = 12'h207;
  localparam logic [11:0] IDX_PERIOD = 12'h208;
  localparam logic [11:0] IDX_SRC_MODE = 12'h20c;
  localparam logic [11:0] IDX_SELECT = 12'h20d;
  localparam logic [11:0] IDX_RDIV = 12'h20e;
  localparam logic [11:0] IDX_LINK_CTRL = 12'h210;
  localparam logic [11:0] IDX_STATUS = 12'h211;
  localparam logic [11:0] IDX_FREQ_BASE = 12'h220;
  localparam logic [11:0] IDX_PHASE_BASE = 12'h228;
  localparam logic [11:0] IDX_DELAY_BASE = 12'h230;
  localparam int ADDR_W = 14;
  // Field positions
  localparam int PERIOD_EXP_LSB = 0;
  localparam int PERIOD_EXP_W = 3;
  localparam int SRC_MODE_BIT = 0;
  localparam int SELECT_LSB = 0;
  localparam int PRESET_IDX_W = 3;
  localparam int LINK_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] THR_I_RST = 8'hf2;
  localparam logic [7:0] THR_Q_RST = 8'hab;
  localparam logic [2:0] PERIOD_EXP_RST = 3'h0;
  localparam logic SRC_MODE_RST = 1'b0;
  localparam logic LINK_EN_RST = 1'b0;
  localparam logic [2:0] SELECT_RST = 3'h0;
  localparam logic [15:0] RDIV_RST = 16'h0000;
  localparam logic [31:0] FREQ_RST = 32'hc0000000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [7:0] DELAY_RST = 8'hff;
  // Threshold scale: thresholds are fractions of 256 of full scale
  localparam int THR_FRAC_W = 8;
  // Rational divisor multiplier is 128
  localparam int RDIV_SHIFT = 7;
  localparam int MOD_W = 16 + RDIV_SHIFT;
  // Base monitoring period in samples, scaled by two to the period exponent
  localparam int OVR_BASE_PERIOD = 16;
endpackage

/* include/nco_cfg_if.sv */
// Bundle between the control core and the oscillator phase accumulator
`timescale 1ns/1ns
interface nco_cfg_if;
  logic [31:0] freq_word;
  logic [15:0] phase_word;
  logic [15:0] rdiv;
  logic [31:0] phase;
  logic [22:0] modulus;
  modport ctrl (output freq_word, output phase_word, output rdiv, input phase, input modulus);
  modport nco (input freq_word, input phase_word, input rdiv, output phase, output modulus);
endinterface

/* logic/ovr_detect.sv */
// Per-channel overrange detector with monitoring-window hold
`timescale 1ns/1ns
module ovr_detect
  import ddc_ctrl_pkg::*;
#(
  parameter int SAMPLE_W = 15
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic valid_i,
  input wire logic signed [SAMPLE_W-1:0] sample_i,
  input wire logic [7:0] threshold_i,
  input wire logic window_end_i,
  output logic flag_o
);
  logic [SAMPLE_W-1:0] mag;
  logic [SAMPLE_W-1:0] level;
  logic exceed;
  logic held_q;

  if (SAMPLE_W < THR_FRAC_W + 2) begin : g_chk
    $error("ovr_detect: SAMPLE_W too small");
  end

  // Magnitude against threshold scaled as a fraction of 256 of full scale
  always_comb begin
    mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : SAMPLE_W'(sample_i);
    level = SAMPLE_W'({threshold_i, {(SAMPLE_W-1-THR_FRAC_W){1'b0}}});
    exceed = valid_i && (mag >= level);
  end

  // Hold over the window; a new exceed wins over the window-end clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_q <= 1'b0;
    end else if (exceed) begin
      held_q <= 1'b1;
    end else if (window_end_i) begin
      held_q <= 1'b0;
    end
  end

  assign flag_o = exceed | held_q;
endmodule

/* logic/nco_accum.sv */
// Oscillator phase accumulator, plain 32-bit or rational modulus
`timescale 1ns/1ns
module nco_accum
  import ddc_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  nco_cfg_if.nco cfg
);
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [MOD_W-1:0] modulus;
  logic [MOD_W:0] rsum;
  logic [MOD_W+15:0] ph_prod;
  logic [MOD_W:0] psum;
  logic rational;

  // Modulus is 128 times the divisor; zero divisor means plain binary wrap
  always_comb begin
    rational = (cfg.rdiv != 16'h0000);
    modulus = {cfg.rdiv, {RDIV_SHIFT{1'b0}}};
    rsum = {1'b0, acc_q[MOD_W-1:0]} + {1'b0, cfg.freq_word[MOD_W-1:0]};
    if (!rational) begin
      acc_d = acc_q + cfg.freq_word;
    end else if (rsum >= {1'b0, modulus}) begin
      acc_d = 32'(rsum - {1'b0, modulus});
    end else begin
      acc_d = 32'(rsum);
    end
  end

  // Accumulator runs on every sample clock
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= 32'h00000000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Phase offset MSB-justified, scaled onto the modulus in rational mode
  always_comb begin
    ph_prod = {{MOD_W{1'b0}}, cfg.phase_word} * {16'h0000, modulus};
    psum = {1'b0, acc_q[MOD_W-1:0]} + {1'b0, ph_prod[MOD_W+15:16]};
    if (!rational) begin
      cfg.phase = acc_q + {cfg.phase_word, 16'h0000};
    end else if (psum >= {1'b0, modulus}) begin
      cfg.phase = 32'(psum - {1'b0, modulus});
    end else begin
      cfg.phase = 32'(psum);
    end
    cfg.modulus = rational ? modulus : 23'h000000;
  end
endmodule

/* logic/ddc_overrange_and_nco_preset_ctrl.sv */
// Overrange flagging and oscillator preset control for the down-converter
`timescale 1ns/1ns
module ddc_overrange_and_nco_preset_ctrl
  import ddc_ctrl_pkg::*;
#(
  parameter int SAMPLE_W = 15,
  parameter int NUM_PRESETS = 8,
  parameter int BASE_PERIOD = OVR_BASE_PERIOD
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Preset index pins, asynchronous
  input wire logic [2:0] preset_index_pins_i,
  // Down-converter output samples
  input wire logic sample_valid_i,
  input wire logic signed [SAMPLE_W-1:0] sample_i_i,
  input wire logic signed [SAMPLE_W-1:0] sample_q_i,
  // Samples with attached flag bits towards the link transmitter
  output logic link_valid_o,
  output logic [SAMPLE_W:0] link_i_o,
  output logic [SAMPLE_W:0] link_q_o,
  output logic link_encoder_enable_o,
  // Active preset towards the down-converter datapath
  output logic [2:0] active_preset_o,
  output logic [31:0] osc_frequency_word_o,
  output logic [15:0] osc_phase_offset_o,
  output logic [7:0] downconv_delay_setting_o,
  output logic [31:0] osc_phase_o,
  output logic [22:0] osc_modulus_o
);
  // Window counter width covers the longest scaled period
  localparam int WIN_W = $clog2(BASE_PERIOD) + 8;

  // Refuse parameter values the logic cannot serve
  if (NUM_PRESETS != 8) begin : g_chk_presets
    $error("NUM_PRESETS must be 8 for a 3-bit index");
  end
  if (BASE_PERIOD < 1 || BASE_PERIOD > 4096) begin : g_chk_period
    $error("BASE_PERIOD out of range");
  end
  if (SAMPLE_W < THR_FRAC_W + 2) begin : g_chk_width
    $error("SAMPLE_W too narrow for an 8-bit threshold");
  end
  if (PRESET_IDX_W != $clog2(NUM_PRESETS)) begin : g_chk_index
    $error("Preset index width does not match NUM_PRESETS");
  end

  // Bundle towards the phase accumulator
  nco_cfg_if nco_bus ();

  // Configuration registers
  logic [7:0] overrange_threshold_i_q;
  logic [7:0] overrange_threshold_q_q;
  logic [2:0] overrange_period_exp_q;
  logic preset_source_mode_q;
  logic [2:0] preset_index_select_q;
  logic [15:0] rational_step_divisor_q;
  logic link_encoder_enable_q;
  logic [31:0] freq_q [NUM_PRESETS];
  logic [15:0] phase_q [NUM_PRESETS];
  logic [7:0] delay_q [NUM_PRESETS];

  // Bus decode
  logic [11:0] idx;
  logic word_ok;
  logic [2:0] sub;
  assign idx = reg_addr_i[ADDR_W-1:2];
  assign word_ok = (reg_addr_i[1:0] == 2'b00);
  assign sub = idx[2:0];

  // Threshold, period and link control writes
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overrange_threshold_i_q <= THR_I_RST;
      overrange_threshold_q_q <= THR_Q_RST;
      overrange_period_exp_q <= PERIOD_EXP_RST;
      link_encoder_enable_q <= LINK_EN_RST;
    end else if (reg_wr_i && word_ok) begin
      case (idx)
        IDX_THR_I: overrange_threshold_i_q <= reg_wdata_i[7:0];
        IDX_THR_Q: overrange_threshold_q_q <= reg_wdata_i[7:0];
        IDX_PERIOD: begin
          overrange_period_exp_q <= reg_wdata_i[PERIOD_EXP_LSB +: PERIOD_EXP_W];
        end
        IDX_LINK_CTRL: link_encoder_enable_q <= reg_wdata_i[LINK_EN_BIT];
        default: ;
      endcase
    end
  end

  // Preset source, select and shared divisor writes
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      preset_source_mode_q <= SRC_MODE_RST;
      preset_index_select_q <= SELECT_RST;
      rational_step_divisor_q <= RDIV_RST;
    end else if (reg_wr_i && word_ok) begin
      case (idx)
        IDX_SRC_MODE: preset_source_mode_q <= reg_wdata_i[SRC_MODE_BIT];
        IDX_SELECT: preset_index_select_q <= reg_wdata_i[SELECT_LSB +: PRESET_IDX_W];
        IDX_RDIV: rational_step_divisor_q <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Preset table: eight frequency, phase and delay entries
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int p = 0; p < NUM_PRESETS; p++) begin
        freq_q[p] <= FREQ_RST;
        phase_q[p] <= PHASE_RST;
        delay_q[p] <= DELAY_RST;
      end
    end else if (reg_wr_i && word_ok) begin
      if (idx[11:3] == IDX_FREQ_BASE[11:3]) begin
        freq_q[sub] <= reg_wdata_i;
      end
      if (idx[11:3] == IDX_PHASE_BASE[11:3]) begin
        phase_q[sub] <= reg_wdata_i[15:0];
      end
      if (idx[11:3] == IDX_DELAY_BASE[11:3]) begin
        delay_q[sub] <= reg_wdata_i[7:0];
      end
    end
  end

  // Two-flop synchroniser on the preset pins; only the second stage feeds
  // the preset choice, so no metastable first-stage value can pick an entry
  logic [2:0] pins_meta_q;
  logic [2:0] pins_sync_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pins_meta_q <= 3'h0;
      pins_sync_q <= 3'h0;
    end else begin
      pins_meta_q <= preset_index_pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  // Active preset choice by source mode
  // Register mode acts on the next clock, pin mode on the third clock after a pin change
  logic [2:0] preset_sel;
  always_comb begin
    if (preset_source_mode_q) begin
      preset_sel = preset_index_select_q;
    end else begin
      preset_sel = pins_sync_q;
    end
  end

  // Frequency, phase and delay of the chosen preset applied together
  logic [2:0] active_q;
  logic [31:0] act_freq_q;
  logic [15:0] act_phase_q;
  logic [7:0] act_delay_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_q <= 3'h0;
      act_freq_q <= FREQ_RST;
      act_phase_q <= PHASE_RST;
      act_delay_q <= DELAY_RST;
    end else begin
      active_q <= preset_sel;
      act_freq_q <= freq_q[preset_sel];
      act_phase_q <= phase_q[preset_sel];
      act_delay_q <= delay_q[preset_sel];
    end
  end

  // Active preset outputs
  assign active_preset_o = active_q;
  assign osc_frequency_word_o = act_freq_q;
  assign osc_phase_offset_o = act_phase_q;
  assign downconv_delay_setting_o = act_delay_q;

  // Accumulator configuration: one divisor for every preset
  assign nco_bus.freq_word = act_freq_q;
  assign nco_bus.phase_word = act_phase_q;
  assign nco_bus.rdiv = rational_step_divisor_q;

  // Phase accumulator shared by all presets
  nco_accum u_nco (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cfg(nco_bus.nco)
  );

  // Registered accumulator phase and modulus
  logic [31:0] osc_phase_q;
  logic [22:0] osc_modulus_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_phase_q <= 32'h00000000;
      osc_modulus_q <= 23'h000000;
    end else begin
      osc_phase_q <= nco_bus.phase;
      osc_modulus_q <= nco_bus.modulus;
    end
  end

  // Accumulator outputs
  assign osc_phase_o = osc_phase_q;
  assign osc_modulus_o = osc_modulus_q;

  // Monitoring window length doubles with each exponent step
  logic [WIN_W-1:0] win_len;
  logic [WIN_W-1:0] win_cnt_q;
  logic win_end;
  always_comb begin
    win_len = WIN_W'(BASE_PERIOD) << overrange_period_exp_q;
    win_end = sample_valid_i && (win_cnt_q == win_len - WIN_W'(1));
  end

  // Window counter held at zero while the link encoder is off, so a
  // period change made then starts the window at the first sample
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_cnt_q <= '0;
    end else if (!link_encoder_enable_q) begin
      win_cnt_q <= '0;
    end else if (win_end || win_cnt_q >= win_len) begin
      win_cnt_q <= '0;
    end else if (sample_valid_i) begin
      win_cnt_q <= win_cnt_q + WIN_W'(1);
    end
  end

  // Overrange detectors for I and Q
  logic flag_i;
  logic flag_q;
  ovr_detect #(.SAMPLE_W(SAMPLE_W)) u_ovr_i (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .valid_i(sample_valid_i),
    .sample_i(sample_i_i),
    .threshold_i(overrange_threshold_i_q),
    .window_end_i(win_end),
    .flag_o(flag_i)
  );
  ovr_detect #(.SAMPLE_W(SAMPLE_W)) u_ovr_q (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .valid_i(sample_valid_i),
    .sample_i(sample_q_i),
    .threshold_i(overrange_threshold_q_q),
    .window_end_i(win_end),
    .flag_o(flag_q)
  );

  // Samples leave with their flag bit in bit 0
  logic link_valid_q;
  logic [SAMPLE_W:0] link_i_q;
  logic [SAMPLE_W:0] link_q_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_valid_q <= 1'b0;
      link_i_q <= '0;
      link_q_q <= '0;
    end else begin
      link_valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        link_i_q <= {sample_i_i, flag_i};
        link_q_q <= {sample_q_i, flag_q};
      end
    end
  end

  // Link outputs
  assign link_valid_o = link_valid_q;
  assign link_i_o = link_i_q;
  assign link_q_o = link_q_q;
  assign link_encoder_enable_o = link_encoder_enable_q;

  // Read mux, answered one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (word_ok) begin
      case (idx)
        IDX_THR_I: rd_mux = {24'h000000, overrange_threshold_i_q};
        IDX_THR_Q: rd_mux = {24'h000000, overrange_threshold_q_q};
        IDX_PERIOD: rd_mux = {29'h00000000, overrange_period_exp_q};
        IDX_SRC_MODE: rd_mux = {31'h00000000, preset_source_mode_q};
        IDX_SELECT: rd_mux = {29'h00000000, preset_index_select_q};
        IDX_RDIV: rd_mux = {16'h0000, rational_step_divisor_q};
        IDX_LINK_CTRL: rd_mux = {31'h00000000, link_encoder_enable_q};
        IDX_STATUS: rd_mux = {24'h000000, flag_q, flag_i, 3'h0, active_q};
        default: begin
          if (idx[11:3] == IDX_FREQ_BASE[11:3]) begin
            rd_mux = freq_q[sub];
          end else if (idx[11:3] == IDX_PHASE_BASE[11:3]) begin
            rd_mux = {16'h0000, phase_q[sub]};
          end else if (idx[11:3] == IDX_DELAY_BASE[11:3]) begin
            rd_mux = {24'h000000, delay_q[sub]};
          end
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  logic [31:0] rdata_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // Read data output
  assign reg_rdata_o = rdata_q;
endmodule

/* tb/link_rx_model.sv */
// Link receiver model that latches each flagged sample pair
`timescale 1ns/1ns
module link_rx_model #(
  parameter int SAMPLE_W = 15
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic valid_i,
  input wire logic [SAMPLE_W:0] data_i_i,
  input wire logic [SAMPLE_W:0] data_q_i,
  output logic [SAMPLE_W:0] last_i_o,
  output logic [SAMPLE_W:0] last_q_o,
  output logic [15:0] count_o
);
  // Take each pair on its valid cycle and count them
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_i_o <= '0;
      last_q_o <= '0;
      count_o <= 16'h0000;
    end else if (valid_i) begin
      last_i_o <= data_i_i;
      last_q_o <= data_q_i;
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

/* tb/ddc_ctrl_monitor.sv */
// Concurrent checks on the overrange and preset control ports
`timescale 1ns/1ns
module ddc_ctrl_monitor
  import ddc_ctrl_pkg::*;
#(
  parameter int SAMPLE_W = 15
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic signed [SAMPLE_W-1:0] sample_i_i,
  input wire logic signed [SAMPLE_W-1:0] sample_q_i,
  input wire logic link_valid_o,
  input wire logic [SAMPLE_W:0] link_i_o,
  input wire logic [SAMPLE_W:0] link_q_o,
  input wire logic [2:0] active_preset_o,
  input wire logic [31:0] osc_frequency_word_o,
  input wire logic [15:0] osc_phase_offset_o,
  input wire logic [31:0] osc_phase_o,
  input wire logic [22:0] osc_modulus_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Full-scale magnitude always exceeds any threshold
  sequence s_q_full;
    sample_valid_i &&
      (sample_q_i[SAMPLE_W-1] ? ~|sample_q_i[SAMPLE_W-2:0] : &sample_q_i[SAMPLE_W-2:0]);
  endsequence
  sequence s_i_full;
    sample_valid_i &&
      (sample_i_i[SAMPLE_W-1] ? ~|sample_i_i[SAMPLE_W-2:0] : &sample_i_i[SAMPLE_W-2:0]);
  endsequence
  property p_valid; link_valid_o == $past(sample_valid_i); endproperty
  property p_q_data; sample_valid_i |=> link_q_o[SAMPLE_W:1] == $past(sample_q_i); endproperty
  property p_i_data; sample_valid_i |=> link_i_o[SAMPLE_W:1] == $past(sample_i_i); endproperty
  property p_q_full; s_q_full |=> link_q_o[0]; endproperty
  property p_i_full; s_i_full |=> link_i_o[0]; endproperty
  property p_hold; !sample_valid_i |=> $stable(link_q_o) && $stable(link_i_o); endproperty
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  property p_rd_bad; reg_rd_i && reg_addr_i[1:0] != 2'h0 |=> reg_rdata_o == 32'h0; endproperty
  property p_mod_step; osc_modulus_o[6:0] == 7'h00; endproperty
  property p_plain_acc;
    (osc_modulus_o == 23'h0 && $stable(osc_frequency_word_o) && $stable(osc_phase_offset_o))[*4]
      |-> osc_phase_o - $past(osc_phase_o) == osc_frequency_word_o;
  endproperty
  a_valid: assert property (p_valid) else $error("link valid misplaced");
  a_q_data: assert property (p_q_data) else $error("Q sample altered");
  a_i_data: assert property (p_i_data) else $error("I sample altered");
  a_q_full: assert property (p_q_full) else $error("Q flag missing at full scale");
  a_i_full: assert property (p_i_full) else $error("I flag missing at full scale");
  a_hold: assert property (p_hold) else $error("link data moved without a sample");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  a_rd_bad: assert property (p_rd_bad) else $error("misaligned read returned data");
  a_mod_step: assert property (p_mod_step) else $error("modulus not a multiple of 128");
  a_plain_acc: assert property (p_plain_acc) else $error("phase step differs");
  c_q_flag: cover property (sample_valid_i ##1 link_q_o[0]);
  c_rational: cover property (osc_modulus_o != 23'h0);
  c_preset7: cover property (active_preset_o == 3'h7);
endmodule
bind ddc_overrange_and_nco_preset_ctrl ddc_ctrl_monitor #(.SAMPLE_W(SAMPLE_W)) mon_inst (
  .mclk_i, .arst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .sample_i_i,
  .sample_q_i, .link_valid_o, .link_i_o, .link_q_o, .active_preset_o, .osc_frequency_word_o,
  .osc_phase_offset_o, .osc_phase_o, .osc_modulus_o
);

/* tb/tb_top.sv */
// Self-checking bench for overrange flagging and preset control
`timescale 1ns/1ns
module tb_top;
  import ddc_ctrl_pkg::*;
  localparam int SW = 15;
  localparam int BP = 4;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [2:0] preset_index_pins_i = 3'h0;
  logic sample_valid_i = 1'b0;
  logic signed [SW-1:0] sample_i_i = '0;
  logic signed [SW-1:0] sample_q_i = '0;
  logic link_valid_o;
  logic [SW:0] link_i_o;
  logic [SW:0] link_q_o;
  logic link_encoder_enable_o;
  logic [2:0] active_preset_o;
  logic [31:0] osc_frequency_word_o;
  logic [15:0] osc_phase_offset_o;
  logic [7:0] downconv_delay_setting_o;
  logic [31:0] osc_phase_o;
  logic [22:0] osc_modulus_o;
  logic [SW:0] rx_i;
  logic [SW:0] rx_q;
  logic [15:0] rx_cnt;
  int bad_count = 0;
  int total_checks = 0;
  int sent = 0;
  ddc_overrange_and_nco_preset_ctrl #(.SAMPLE_W(SW), .BASE_PERIOD(BP))
    ddc_overrange_and_nco_preset_ctrl_inst (
    .mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .preset_index_pins_i, .sample_valid_i, .sample_i_i, .sample_q_i, .link_valid_o, .link_i_o,
    .link_q_o, .link_encoder_enable_o, .active_preset_o, .osc_frequency_word_o,
    .osc_phase_offset_o, .downconv_delay_setting_o, .osc_phase_o, .osc_modulus_o
  );
  link_rx_model #(.SAMPLE_W(SW)) link_rx_model_inst (.mclk_i, .arst_n_i, .valid_i(link_valid_o),
    .data_i_i(link_i_o), .data_q_i(link_q_o), .last_i_o(rx_i), .last_q_o(rx_q), .count_o(rx_cnt));
  // Clock source
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= {idx, 2'b00};
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask
  // One sample pair, then wait until the receiver holds it
  task automatic smp(input logic signed [SW-1:0] a, input logic signed [SW-1:0] b);
    @(posedge mclk_i);
    sample_valid_i <= 1'b1;
    sample_i_i <= a;
    sample_q_i <= b;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    sent++;
    repeat (2) @(negedge mclk_i);
  endtask
  task automatic pchk(input int k);
    chk(active_preset_o, k);
    chk(osc_frequency_word_o, (32'(k) << 28) + 32'h11);
    chk(osc_phase_offset_o, 32'h100 * k + 3);
    chk(downconv_delay_setting_o, k + 32'h40);
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    int n;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd({IDX_THR_I, 2'b00}, 32'hf2);
    rd({IDX_THR_Q, 2'b00}, 32'hab);
    rd({IDX_PERIOD, 2'b00}, 32'h0);
    rd({IDX_SRC_MODE, 2'b00}, 32'h0);
    rd({IDX_SELECT, 2'b00}, 32'h0);
    rd({IDX_RDIV, 2'b00}, 32'h0);
    chk(osc_frequency_word_o, FREQ_RST);
    $display("reset test done");
    smp(15'sd15487, 15'sd10943);
    chk(rx_i[0], 0);
    chk(rx_q, {15'd10943, 1'b0});
    smp(-15'sd15488, -15'sd10944);
    chk(rx_i[0], 1);
    chk(rx_q[0], 1);
    smp(15'sd16383, -15'sd16384);
    $display("threshold test done");
    wr(IDX_THR_Q, 32'h80);
    wr(IDX_LINK_CTRL, 32'h1);
    for (int e = 0; e < 3; e++) begin
      wr(IDX_PERIOD, e);
      smp(0, 15'sd8192);
      for (int k = 0; k < 40 && rx_q[0] !== 1'b0; k++) smp(0, 15'sd8191);
      smp(0, -15'sd8192);
      n = 0;
      for (int k = 0; k < 40 && rx_q[0] === 1'b1; k++) begin
        n++;
        smp(0, 0);
      end
      chk(n, (BP << e) - 1);
    end
    chk(link_encoder_enable_o, 1);
    rd({IDX_PERIOD, 2'b00}, 32'h2);
    rd({IDX_PERIOD, 2'b01}, 32'h0);
    // Period changed with the encoder off: window starts at the next sample
    wr(IDX_LINK_CTRL, 32'h0);
    wr(IDX_PERIOD, 32'h1);
    wr(IDX_LINK_CTRL, 32'h1);
    smp(0, -15'sd8192);
    n = 0;
    for (int k = 0; k < 40 && rx_q[0] === 1'b1; k++) begin
      n++;
      smp(0, 0);
    end
    chk(n, BP << 1);
    chk(rx_cnt, sent);
    $display("period test done");
    for (int k = 0; k < 8; k++) begin
      wr(IDX_FREQ_BASE + 12'(k), (32'(k) << 28) + 32'h11);
      wr(IDX_PHASE_BASE + 12'(k), 32'h100 * k + 3);
      wr(IDX_DELAY_BASE + 12'(k), k + 32'h40);
    end
    wr(IDX_SRC_MODE, 32'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      preset_index_pins_i <= 3'(7 - k);
      wr(IDX_SELECT, k);
      repeat (4) @(negedge mclk_i);
      pchk(k);
      rd({IDX_STATUS, 2'b00}, 32'(k));
    end
    wr(IDX_SRC_MODE, 32'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      preset_index_pins_i <= 3'(k);
      wr(IDX_SELECT, 7 - k);
      repeat (4) @(negedge mclk_i);
      pchk(k);
      rd({IDX_DELAY_BASE + 12'(k), 2'b00}, k + 32'h40);
    end
    $display("preset test done");
    wr(IDX_SRC_MODE, 32'h1);
    wr(IDX_RDIV, 32'd2400); // Integer divisor under 8192
    for (int k = 3; k < 7; k += 3) begin
      wr(IDX_FREQ_BASE + 12'(k), 32'h100); // Kept below the modulus
      wr(IDX_SELECT, k);
      repeat (3) @(negedge mclk_i);
      chk(osc_modulus_o, 32'd307200);
    end
    rd({IDX_RDIV, 2'b00}, 32'd2400);
    wr(IDX_RDIV, 32'h0);
    repeat (8) @(negedge mclk_i);
    chk(osc_modulus_o, 0);
    $display("divisor test done");
    end_sim();
  end
endmodule
